// *** verilog/port_one_pkg.sv ***
// Constants for the three-pin port one block: pin positions, modes, reset values.
// Assumes a single 50 MHz clock domain.
package port_one_pkg;
    localparam int PORT_WIDTH = 6;
    localparam int BIT_ZERO = 0;
    localparam int BIT_ONE = 1;
    localparam int BIT_FIVE = 5;
    localparam logic [5:0] PIN_MASK = 6'h23;
    // Output type per configurable pin
    typedef enum logic [1:0] {
        MODE_QUASI = 2'b00,
        MODE_PUSH = 2'b01,
        MODE_INPUT = 2'b10,
        MODE_OPEN = 2'b11
    } out_mode_e;
    localparam logic [1:0] MODE_RESET = 2'b10;
    localparam logic [5:0] LATCH_RESET = 6'h23;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // Power-on window during which the reset pin is always honoured
    localparam int POR_TIME_US = 100;
    localparam int CLK_MHZ = 50;
    localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
    // Cycles the reset pin must stay low at power-on to request programming mode
    localparam int PROG_HOLD_CYCLES = 16;
    localparam int SYNC_STAGES = 2;
endpackage : port_one_pkg

// *** verilog/port_one_pin_cell.sv ***
// One configurable bidirectional port pin: latch, output type, pin drive.
// Assumes the pin input is already synchronous to the clock.
`timescale 1ns/10ps
module port_one_pin_cell
    import port_one_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    // Configuration writes
    input wire logic i_mode_we,
    input wire logic [1:0] i_mode,
    input wire logic i_latch_we,
    input wire logic i_latch,
    // Alternate function
    input wire logic i_alt_en,
    input wire logic i_alt_out,
    // Pin
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe,
    output logic o_pullup,
    output logic o_in,
    output logic [1:0] o_mode
);
    import port_one_pkg::*;

    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic latch_q;
    logic latch_d;
    logic drive_val;

    always_comb
    begin
        mode_d = mode_q;
        latch_d = latch_q;
        if (i_soft_rst)
        begin
            mode_d = MODE_RESET;
            latch_d = 1'b1;
        end
        else
        begin
            if (i_mode_we)
                mode_d = i_mode;
            if (i_latch_we)
                latch_d = i_latch;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_q <= MODE_RESET;
            latch_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            latch_q <= latch_d;
        end
    end

    always_comb
    begin
        drive_val = i_alt_en ? i_alt_out : latch_q;
        o_pin = drive_val;
        o_pin_oe = 1'b0;
        o_pullup = 1'b0;
        unique case (out_mode_e'(mode_q))
            MODE_QUASI:
            begin
                o_pin_oe = ~drive_val;
                o_pullup = 1'b1;
            end
            MODE_PUSH: o_pin_oe = 1'b1;
            MODE_INPUT: o_pin_oe = 1'b0;
            MODE_OPEN: o_pin_oe = ~drive_val;
        endcase
    end

    assign o_in = i_pin;
    assign o_mode = mode_q;
endmodule : port_one_pin_cell

// *** verilog/port_one_pins.sv ***
// Port one pin block: bits 0 and 1 bidirectional, bit 5 input or reset.
// Assumes the core gives latch and mode writes and uses the reset outputs.
`timescale 1ns/10ps
module port_one_pins
    import port_one_pkg::*;
#(
    parameter int POR_COUNT = POR_CYCLES,
    parameter int PROG_HOLD = PROG_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // User configuration: reset pin function select
    input wire logic I_RST_PIN_EN,
    // Core side configuration writes
    input wire logic I_MODE_WE0,
    input wire logic I_MODE_WE1,
    input wire logic [1:0] I_MODE,
    input wire logic [port_one_pkg::PORT_WIDTH-1:0] I_LATCH_WE,
    input wire logic [port_one_pkg::PORT_WIDTH-1:0] I_LATCH,
    // Serial port
    input wire logic I_SER_TX_EN,
    input wire logic I_SER_TX,
    output logic O_SER_RX,
    // Pins
    input wire logic [port_one_pkg::PORT_WIDTH-1:0] I_PIN,
    output logic [port_one_pkg::PORT_WIDTH-1:0] O_PIN,
    output logic [port_one_pkg::PORT_WIDTH-1:0] O_PIN_OE,
    output logic [port_one_pkg::PORT_WIDTH-1:0] O_PULLUP,
    // Core side status
    output logic [port_one_pkg::PORT_WIDTH-1:0] O_PORT_IN,
    output logic [3:0] O_MODES,
    output logic O_CHIP_RST,
    output logic [15:0] O_FETCH_ADDR,
    output logic O_POR_DONE,
    output logic O_PROG_MODE
);
    import port_one_pkg::*;

    logic [31:0] por_cnt_q;
    logic [31:0] por_cnt_d;
    logic por_done_q;
    logic por_done_d;
    logic [7:0] prog_cnt_q;
    logic [7:0] prog_cnt_d;
    logic prog_q;
    logic prog_d;
    logic rst_fn_active;
    logic pin_rst;
    logic rst_held_q;
    logic rst_held_d;
    logic rx_q;
    logic rx_d;
    logic [5:0] in_d;
    logic [5:0] in_q;
    logic pin0_out;
    logic pin0_oe;
    logic pin0_pu;
    logic pin0_in;
    logic pin1_out;
    logic pin1_oe;
    logic pin1_pu;
    logic pin1_in;

    // Reset pin is honoured during power-on regardless of configuration
    assign rst_fn_active = !por_done_q || I_RST_PIN_EN;
    assign pin_rst = rst_fn_active && !I_PIN[BIT_FIVE];

    // Counter stops at the end of the window, so it never wraps
    always_comb
    begin
        por_cnt_d = por_cnt_q;
        por_done_d = por_done_q;
        prog_cnt_d = prog_cnt_q;
        prog_d = prog_q;
        rst_held_d = pin_rst;
        if (!por_done_q)
        begin
            if (por_cnt_q >= 32'(POR_COUNT - 1))
                por_done_d = 1'b1;
            else
                por_cnt_d = por_cnt_q + 32'h1;
            // Low pin held long enough during power-on requests programming mode
            if (!I_PIN[BIT_FIVE])
            begin
                if (prog_cnt_q >= 8'(PROG_HOLD - 1))
                    prog_d = 1'b1;
                else
                    prog_cnt_d = prog_cnt_q + 8'h1;
            end
            else
                prog_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            por_cnt_q <= 32'h0;
            por_done_q <= 1'b0;
            prog_cnt_q <= 8'h00;
            prog_q <= 1'b0;
            rst_held_q <= 1'b0;
        end
        else
        begin
            por_cnt_q <= por_cnt_d;
            por_done_q <= por_done_d;
            prog_cnt_q <= prog_cnt_d;
            prog_q <= prog_d;
            rst_held_q <= rst_held_d;
        end
    end

    port_one_pin_cell u_bit0 (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_soft_rst(pin_rst),
        .i_mode_we(I_MODE_WE0),
        .i_mode(I_MODE),
        .i_latch_we(I_LATCH_WE[BIT_ZERO]),
        .i_latch(I_LATCH[BIT_ZERO]),
        .i_alt_en(I_SER_TX_EN),
        .i_alt_out(I_SER_TX),
        .i_pin(I_PIN[BIT_ZERO]),
        .o_pin(pin0_out),
        .o_pin_oe(pin0_oe),
        .o_pullup(pin0_pu),
        .o_in(pin0_in),
        .o_mode(O_MODES[1:0])
    );

    port_one_pin_cell u_bit1 (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_soft_rst(pin_rst),
        .i_mode_we(I_MODE_WE1),
        .i_mode(I_MODE),
        .i_latch_we(I_LATCH_WE[BIT_ONE]),
        .i_latch(I_LATCH[BIT_ONE]),
        .i_alt_en(1'b0),
        .i_alt_out(1'b0),
        .i_pin(I_PIN[BIT_ONE]),
        .o_pin(pin1_out),
        .o_pin_oe(pin1_oe),
        .o_pullup(pin1_pu),
        .o_in(pin1_in),
        .o_mode(O_MODES[3:2])
    );

    // Only bits 0 and 1 may drive; bit five and unused bits stay off
    always_comb
    begin
        O_PIN = 6'h00;
        O_PIN_OE = 6'h00;
        O_PULLUP = 6'h00;
        O_PIN[BIT_ZERO] = pin0_out;
        O_PIN_OE[BIT_ZERO] = pin0_oe;
        O_PULLUP[BIT_ZERO] = pin0_pu;
        O_PIN[BIT_ONE] = pin1_out;
        O_PIN_OE[BIT_ONE] = pin1_oe;
        O_PULLUP[BIT_ONE] = pin1_pu;
    end

    // Port input register; bit five reads as data only when not a reset pin
    always_comb
    begin
        in_d = 6'h00;
        in_d[BIT_ZERO] = pin0_in;
        in_d[BIT_ONE] = pin1_in;
        in_d[BIT_FIVE] = rst_fn_active ? 1'b1 : I_PIN[BIT_FIVE];
    end

    // Receive follows bit one through one flop; idle line level is high
    always_comb
    begin
        rx_d = pin1_in;
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            rx_q <= 1'b1;
        else
            rx_q <= rx_d;
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            in_q <= 6'h00;
        end
        else
        begin
            in_q <= in_d & PIN_MASK;
        end
    end

    assign O_PORT_IN = in_q;
    // Status comes from flops, so the core never sees a pin glitch
    assign O_SER_RX = rx_q;
    assign O_CHIP_RST = rst_held_q;
    assign O_FETCH_ADDR = RESET_VECTOR;
    assign O_POR_DONE = por_done_q;
    assign O_PROG_MODE = prog_q;
endmodule : port_one_pins

// *** bench/port_one_assertions.sv ***
// Checker for the port one pin block, bound to its top module.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module port_one_checker #(
    parameter int POR_COUNT = 20,
    parameter int PROG_HOLD = 4
)
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    // Inputs
    input wire logic I_RST_PIN_EN,
    input wire logic I_MODE_WE0,
    input wire logic I_MODE_WE1,
    input wire logic [1:0] I_MODE,
    input wire logic I_SER_TX_EN,
    input wire logic I_SER_TX,
    input wire logic [5:0] I_PIN,
    // Outputs
    input wire logic O_SER_RX,
    input wire logic [5:0] O_PIN,
    input wire logic [5:0] O_PIN_OE,
    input wire logic [5:0] O_PULLUP,
    input wire logic [5:0] O_PORT_IN,
    input wire logic [3:0] O_MODES,
    input wire logic O_CHIP_RST,
    input wire logic [15:0] O_FETCH_ADDR,
    input wire logic O_POR_DONE,
    input wire logic O_PROG_MODE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // Consecutive low cycles of the reset pin inside the power-on window
    logic [7:0] low_q;
    logic [7:0] low_d;
    always_comb
    begin
        low_d = (!O_POR_DONE && !I_PIN[5]) ? low_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            low_q <= 8'h00;
        else
            low_q <= low_d;
    end
    a_pins_only: assert property (O_PIN_OE[5:2] == 4'h0)
        else $error("unused or input-only pin driven");
    a_reset_inputs: assert property (disable iff (1'b0) !I_RSTN |->
        O_MODES == 4'ha && O_PIN_OE == 6'h00 && O_PULLUP == 6'h00)
        else $error("reset state not input-only");
    a_mode_own: assert property (I_MODE_WE0 && !I_MODE_WE1 && I_PIN[5] && !O_CHIP_RST
        |=> O_MODES == {$past(O_MODES[3:2]), $past(I_MODE)})
        else $error("mode write disturbed other pin");
    a_tx_on_pin: assert property (I_SER_TX_EN && O_PIN_OE[0] |-> O_PIN[0] == I_SER_TX)
        else $error("pin zero not carrying transmit");
    a_rx_follow: assert property ($past(I_RSTN) && $past(I_PIN[5]) |->
        O_SER_RX == $past(I_PIN[1]))
        else $error("receive does not follow pin one");
    a_pin_reset: assert property ((!O_POR_DONE || I_RST_PIN_EN) && !I_PIN[5]
        |=> O_CHIP_RST)
        else $error("low reset pin ignored");
    a_reset_defaults: assert property (O_CHIP_RST |->
        O_MODES == 4'ha && O_FETCH_ADDR == 16'h0000)
        else $error("defaults not applied in pin reset");
    a_prog_entry: assert property (int'(low_q) >= PROG_HOLD |-> ##[0:2] O_PROG_MODE)
        else $error("programming mode not entered");
    a_gpio_five: assert property (O_POR_DONE && !I_RST_PIN_EN
        |=> O_PORT_IN[5] == $past(I_PIN[5]))
        else $error("bit five not read as input");
    c_prog: cover property (O_PROG_MODE);
    c_pin_rst: cover property (O_CHIP_RST && O_POR_DONE);
    c_tx: cover property (I_SER_TX_EN && O_PIN_OE[0]);
endmodule : port_one_checker

// *** bench/link_peer.sv ***
// Board side of port one: reset circuit, serial peer, pull-up on bit zero.
// Assumes the bench sets the reset button and the receive line level.
`timescale 1ns/10ps
module link_peer #(
    parameter int OSC_MHZ = 12
)
(
    // Pin side
    input wire logic [5:0] i_pin,
    input wire logic [5:0] i_oe,
    // Board controls
    input wire logic i_rx,
    input wire logic i_btn_n,
    input wire logic i_sel,
    output logic o_rst_en,
    output logic [5:0] o_lvl
);
    // Fast oscillators force the reset pin function on
    assign o_rst_en = i_sel || (OSC_MHZ > 12);
    // Released bit zero floats high through the board pull-up
    // Bit one shows the peer's line unless the port drives it
    assign o_lvl = {i_btn_n, 3'h0, i_oe[1] ? i_pin[1] : i_rx, i_oe[0] ? i_pin[0] : 1'b1};
endmodule : link_peer

// *** bench/tb.sv ***
// Self-checking bench for the port one pin block.
// Assumes shortened power-on and programming-mode counts.
`timescale 1ns/10ps
module tb;
    import port_one_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic sel = 1'b0;
    logic we0 = 1'b0;
    logic we1 = 1'b0;
    logic [1:0] mode = 2'b00;
    logic [5:0] lwe = 6'h00;
    logic tx_en = 1'b0;
    logic tx = 1'b1;
    logic rx = 1'b1;
    logic btn_n = 1'b0;
    logic cfg_en;
    logic ser_rx;
    logic chip_rst;
    logic por_done;
    logic prog;
    logic [5:0] lvl;
    logic [5:0] pin_o;
    logic [5:0] oe;
    logic [5:0] pu;
    logic [5:0] pin_in;
    logic [3:0] modes;
    logic [15:0] fetch;
    int fail_count = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    port_one_pins #(.POR_COUNT(20), .PROG_HOLD(4)) i_port_one_pins (
        .I_MCLK(clk), .I_RSTN(rst_n), .I_RST_PIN_EN(cfg_en), .I_MODE_WE0(we0),
        .I_MODE_WE1(we1), .I_MODE(mode), .I_LATCH_WE(lwe), .I_LATCH(6'h00),
        .I_SER_TX_EN(tx_en), .I_SER_TX(tx), .O_SER_RX(ser_rx), .I_PIN(lvl),
        .O_PIN(pin_o), .O_PIN_OE(oe), .O_PULLUP(pu), .O_PORT_IN(pin_in),
        .O_MODES(modes), .O_CHIP_RST(chip_rst), .O_FETCH_ADDR(fetch),
        .O_POR_DONE(por_done), .O_PROG_MODE(prog));
    link_peer #(.OSC_MHZ(12)) i_link_peer (.i_pin(pin_o), .i_oe(oe), .i_rx(rx),
        .i_btn_n(btn_n), .i_sel(sel), .o_rst_en(cfg_en), .o_lvl(lvl));
    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Idle cycle after each strobe keeps writes from overlapping
    task automatic wr(input logic pin1, input logic [1:0] m);
        we0 = !pin1;
        we1 = pin1;
        mode = m;
        cyc(1);
        we0 = 1'b0;
        we1 = 1'b0;
        cyc(1);
    endtask : wr
    task automatic t_power_on;
        // A real falling edge, so the asynchronous clear acts before the first clock
        #1;
        rst_n = 1'b0;
        cyc(16);
        chk("modes", 16'h000a, 16'(modes));
        chk("oe_pu", 16'h0000, {4'h0, oe, pu});
        rst_n = 1'b1;
        cyc(6);
        chk("prog", 16'h0001, 16'(prog));
        chk("chip_rst", 16'h0001, 16'(chip_rst));
        chk("fetch", 16'h0000, fetch);
        btn_n = 1'b1;
        for (int i = 0; i < 40 && !por_done; i++)
            cyc(1);
        chk("por_done", 16'h0001, 16'(por_done));
    endtask : t_power_on
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            wr(1'b0, 2'(m));
            chk("modes", 16'(8 + m), 16'(modes));
            chk("pullup0", 16'(m == 0), 16'(pu[0]));
        end
        wr(1'b1, 2'b01);
        chk("modes", 16'h0007, 16'(modes));
        wr(1'b0, 2'b01);
        lwe = 6'h01;
        cyc(1);
        lwe = 6'h00;
        chk("pin0", 16'h0002, {14'h0, oe[0], pin_o[0]});
        chk("oe5", 16'h0000, 16'(oe[5]));
    endtask : t_modes
    task automatic t_serial;
        wr(1'b1, 2'b10);
        tx_en = 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            tx = 1'(b);
            rx = 1'(b);
            cyc(3);
            chk("tx_pin", 16'(2 + b), {14'h0, oe[0], pin_o[0]});
            chk("rx", 16'(b * 3), {14'h0, ser_rx, pin_in[1]});
        end
        tx_en = 1'b0;
    endtask : t_serial
    task automatic t_pin_reset;
        sel = 1'b1;
        btn_n = 1'b0;
        cyc(2);
        chk("chip_rst", 16'h0001, 16'(chip_rst));
        chk("port_in5", 16'h0001, 16'(pin_in[5]));
        wr(1'b0, 2'b01);
        chk("modes", 16'h000a, 16'(modes));
        btn_n = 1'b1;
        cyc(2);
        chk("chip_rst", 16'h0000, 16'(chip_rst));
    endtask : t_pin_reset
    task automatic t_gpio5;
        sel = 1'b0;
        btn_n = 1'b0;
        cyc(3);
        chk("chip_rst", 16'h0000, 16'(chip_rst));
        chk("port_in5", 16'h0000, 16'(pin_in[5]));
        btn_n = 1'b1;
        cyc(3);
        chk("port_in5", 16'h0001, 16'(pin_in[5]));
    endtask : t_gpio5
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        t_power_on();
        t_modes();
        t_serial();
        t_pin_reset();
        t_gpio5();
        wrap_up();
    end
endmodule : tb
bind port_one_pins port_one_checker #(.POR_COUNT(POR_COUNT), .PROG_HOLD(PROG_HOLD))
    i_port_one_checker (.*);
